/* File: rtl/tsbc_channel.v */
// One capture/compare channel of the timer counter core
`timescale 1ns/10ps
`include "tsbc_defines.vh"
module tsbc_channel
(
    input  wire        clk,
    input  wire        resetn,
    input  wire        running,
    input  wire        tick,
    input  wire [15:0] count,
    input  wire        compare_mode,
    input  wire [1:0]  capture_edge_sel,
    input  wire [2:0]  compare_action_sel,
    input  wire        radio_capture_sel,
    input  wire        radio_event,
    input  wire [15:0] compare_value,
    input  wire        pin_in,
    output reg  [15:0] capture_q,
    output reg         pin_out_q,
    output reg         pin_oe_n_q,
    output reg         event_q
);
    reg  pin_meta_q;
    reg  pin_sync_q;
    reg  pin_last_q;
    wire rise;
    wire fall;
    reg  cap_hit;
    wire cmp_hit;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and edge detect
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
            pin_last_q <= 1'b0;
        end
        else
        begin
            pin_meta_q <= pin_in;
            pin_sync_q <= pin_meta_q;
            pin_last_q <= pin_sync_q;
        end
    end
    assign rise = pin_sync_q & ~pin_last_q;
    assign fall = ~pin_sync_q & pin_last_q;

    always @*
    begin
        if (radio_capture_sel)
            cap_hit = radio_event;
        else
        begin
            case (capture_edge_sel)
                `TSBC_CAP_RISE: cap_hit = rise;
                `TSBC_CAP_FALL: cap_hit = fall;
                `TSBC_CAP_BOTH: cap_hit = rise | fall;
                default:        cap_hit = 1'b0;
            endcase
        end
    end
    assign cmp_hit = tick & (count == compare_value);

    ////////////////////////////////////////////////////////////////////////
    // Capture register, compare output, event pulse
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            capture_q  <= `TSBC_COUNT_RST;
            pin_out_q  <= 1'b0;
            pin_oe_n_q <= 1'b1;
            event_q    <= 1'b0;
        end
        else
        begin
            pin_oe_n_q <= ~compare_mode;
            event_q    <= 1'b0;
            if (!compare_mode && running && cap_hit)
            begin
                capture_q <= count;
                event_q   <= 1'b1;
            end
            if (compare_mode && running && cmp_hit)
            begin
                event_q <= 1'b1;
                case (compare_action_sel)
                    `TSBC_CMP_SET:    pin_out_q <= 1'b1;
                    `TSBC_CMP_CLEAR:  pin_out_q <= 1'b0;
                    `TSBC_CMP_TOGGLE: pin_out_q <= ~pin_out_q;
                    default:          pin_out_q <= pin_out_q;
                endcase
            end
        end
    end
endmodule

/* File: rtl/tsbc_defines.vh */
// Constants for the sixteen-bit timer counter core
`ifndef TSBC_DEFINES_VH
`define TSBC_DEFINES_VH
`define TSBC_MODE_STOP    2'h0
`define TSBC_MODE_FREE    2'h1
`define TSBC_MODE_MODULO  2'h2
`define TSBC_MODE_UPDOWN  2'h3
`define TSBC_DIV_1        2'h0
`define TSBC_DIV_8        2'h1
`define TSBC_DIV_32       2'h2
`define TSBC_DIV_128      2'h3
`define TSBC_PRE_8        7'h07
`define TSBC_PRE_32       7'h1F
`define TSBC_PRE_128      7'h7F
`define TSBC_CMP_SET      3'h0
`define TSBC_CMP_CLEAR    3'h1
`define TSBC_CMP_TOGGLE   3'h2
`define TSBC_CAP_NONE     2'h0
`define TSBC_CAP_RISE     2'h1
`define TSBC_CAP_FALL     2'h2
`define TSBC_CAP_BOTH     2'h3
`define TSBC_COUNT_RST    16'h0000
`define TSBC_COUNT_MAX    16'hFFFF
`define TSBC_DSM_ACC_RST  16'h0000
`endif

/* File: rtl/tsbc_timer.v */
// Sixteen-bit timer counter core top
// Function
// - Sixteen-bit count steps once per prescaled tick
// - Prescaler divides tick by 1, 8, 32, 128
// - Tick speed selected apart from system clock
// - Low byte read latches high byte
// - Any low byte write clears count
// - Nonzero mode starts counting
// - Mode 00 freezes count, keeps value
// - Three channels, one pin each
// - Capture on rising, falling or either edge
// - Compare sets, clears or toggles output
// - Free-running, modulo and up/down modes
// - Events for capture, compare, terminal count
// - Radio event may trigger capture
// - Delta-sigma modulator mode offered
// - Free mode wraps FFFF to zero, flags on reaching FFFF
// - Modulo wraps at channel-0 value, flags
// - Up/down turns at channel-0, flags at zero
`timescale 1ns/10ps
`include "tsbc_defines.vh"
module tsbc_timer
(
    input  wire        clk,
    input  wire        resetn,
    input  wire [2:0]  timer_tick_speed_sel,
    input  wire [1:0]  timer_control_reg_mode,
    input  wire [1:0]  prescale_divide_sel,
    input  wire        delta_sigma_output_mode,
    input  wire [15:0] delta_sigma_input,
    input  wire        count_low_read,
    input  wire        count_low_write,
    input  wire        overflow_flag_clear,
    input  wire [15:0] channel0_compare_value,
    input  wire [15:0] channel1_compare_value,
    input  wire [15:0] channel2_compare_value,
    input  wire [2:0]  channel_compare_mode,
    input  wire [5:0]  channel_capture_edge_sel,
    input  wire [8:0]  channel_compare_action_sel,
    input  wire [2:0]  channel_radio_capture_sel,
    input  wire        radio_event,
    input  wire [2:0]  channel_pin_in,
    output reg  [7:0]  count_low_byte,
    output reg  [7:0]  count_high_byte,
    output reg         overflow_flag,
    output reg  [2:0]  channel_event_flag,
    output wire [47:0] channel_capture_value,
    output wire [2:0]  channel_pin_out,
    output wire [2:0]  channel_pin_oe_n,
    output reg         delta_sigma_out_q
);
    reg  [15:0] count_q;
    reg  [15:0] count_d;
    reg         down_q;
    reg         down_d;
    reg         ovf_d;
    reg  [6:0]  tick_div_q;
    reg  [6:0]  pre_q;
    reg  [6:0]  pre_lim;
    reg  [16:0] dsm_acc_q;
    reg         radio_meta_q;
    reg         radio_sync_q;
    reg         radio_last_q;
    wire        tick_spd_en;
    wire        tick;
    wire        running;
    wire [2:0]  ch_event;
    wire [47:0] ch_cmp;

    ////////////////////////////////////////////////////////////////////////
    // Tick speed divider: 2^sel system clocks per tick
    assign tick_spd_en = (tick_div_q & ((7'h01 << timer_tick_speed_sel) - 7'h01)) == 7'h00;
    assign running     = (timer_control_reg_mode != `TSBC_MODE_STOP);

    always @*
    begin
        case (prescale_divide_sel)
            `TSBC_DIV_8:   pre_lim = `TSBC_PRE_8;
            `TSBC_DIV_32:  pre_lim = `TSBC_PRE_32;
            `TSBC_DIV_128: pre_lim = `TSBC_PRE_128;
            default:       pre_lim = 7'h00;
        endcase
    end
    assign tick = running && tick_spd_en && (pre_q >= pre_lim);

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tick_div_q <= 7'h00;
            pre_q      <= 7'h00;
        end
        else
        begin
            tick_div_q <= tick_div_q + 7'h01;
            if (count_low_write || !running)
                pre_q <= 7'h00;
            else if (tick)
                pre_q <= 7'h00;
            else if (tick_spd_en)
                pre_q <= pre_q + 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Count next state per mode
    always @*
    begin
        count_d = count_q;
        down_d  = down_q;
        ovf_d   = 1'b0;
        case (timer_control_reg_mode)
            `TSBC_MODE_FREE:
            begin
                count_d = (count_q == `TSBC_COUNT_MAX) ? `TSBC_COUNT_RST : count_q + 16'h0001;
                ovf_d   = (count_d == `TSBC_COUNT_MAX);
                down_d  = 1'b0;
            end
            `TSBC_MODE_MODULO:
            begin
                count_d = (count_q >= channel0_compare_value) ? `TSBC_COUNT_RST : count_q + 16'h0001;
                ovf_d   = (count_d == channel0_compare_value);
                down_d  = 1'b0;
            end
            `TSBC_MODE_UPDOWN:
            begin
                if (down_q && count_q != `TSBC_COUNT_RST)
                    count_d = count_q - 16'h0001;
                else if (!down_q && count_q >= channel0_compare_value)
                begin
                    count_d = count_q - 16'h0001;
                    down_d  = 1'b1;
                end
                else
                begin
                    count_d = count_q + 16'h0001;
                    down_d  = 1'b0;
                end
                if (count_d == `TSBC_COUNT_RST)
                begin
                    ovf_d  = 1'b1;
                    down_d = 1'b0;
                end
            end
            default:
            begin
                count_d = count_q;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Count, flags and byte latch
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            count_q            <= `TSBC_COUNT_RST;
            down_q             <= 1'b0;
            overflow_flag      <= 1'b0;
            count_low_byte     <= 8'h00;
            count_high_byte    <= 8'h00;
            channel_event_flag <= 3'h0;
        end
        else
        begin
            if (count_low_write)
            begin
                count_q <= `TSBC_COUNT_RST;
                down_q  <= 1'b0;
            end
            else if (tick)
            begin
                count_q <= count_d;
                down_q  <= down_d;
            end
            count_low_byte <= count_q[7:0];
            if (count_low_read)
                count_high_byte <= count_q[15:8];
            if (tick && ovf_d && !count_low_write)
                overflow_flag <= 1'b1;
            else if (overflow_flag_clear)
                overflow_flag <= 1'b0;
            channel_event_flag <= ch_event;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Radio event synchroniser and delta-sigma modulator
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            radio_meta_q      <= 1'b0;
            radio_sync_q      <= 1'b0;
            radio_last_q      <= 1'b0;
            dsm_acc_q         <= {1'b0, `TSBC_DSM_ACC_RST};
            delta_sigma_out_q <= 1'b0;
        end
        else
        begin
            radio_meta_q <= radio_event;
            radio_sync_q <= radio_meta_q;
            radio_last_q <= radio_sync_q;
            if (delta_sigma_output_mode && tick)
            begin
                dsm_acc_q         <= {1'b0, dsm_acc_q[15:0]} + {1'b0, delta_sigma_input};
                delta_sigma_out_q <= dsm_acc_q[16];
            end
            else if (!delta_sigma_output_mode)
            begin
                dsm_acc_q         <= {1'b0, `TSBC_DSM_ACC_RST};
                delta_sigma_out_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Three capture/compare channels
    assign ch_cmp = {channel2_compare_value, channel1_compare_value, channel0_compare_value};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_ch
            tsbc_channel u_ch
            (
                .clk                (clk),
                .resetn             (resetn),
                .running            (running),
                .tick               (tick),
                .count              (count_q),
                .compare_mode       (channel_compare_mode[gi]),
                .capture_edge_sel   (channel_capture_edge_sel[2*gi+1:2*gi]),
                .compare_action_sel (channel_compare_action_sel[3*gi+2:3*gi]),
                .radio_capture_sel  (channel_radio_capture_sel[gi]),
                .radio_event        (radio_sync_q & ~radio_last_q),
                .compare_value      (ch_cmp[16*gi+15:16*gi]),
                .pin_in             (channel_pin_in[gi]),
                .capture_q          (channel_capture_value[16*gi+15:16*gi]),
                .pin_out_q          (channel_pin_out[gi]),
                .pin_oe_n_q         (channel_pin_oe_n[gi]),
                .event_q            (ch_event[gi])
            );
        end
    endgenerate
endmodule

/* File: verif/tsbc_checker.sv */
// Port relation checker of the timer counter core
`timescale 1ns/10ps
module tsbc_checker
(
    input wire       clk,
    input wire       resetn,
    input wire [2:0] timer_tick_speed_sel,
    input wire [1:0] timer_control_reg_mode,
    input wire [1:0] prescale_divide_sel,
    input wire       count_low_read,
    input wire       count_low_write,
    input wire       overflow_flag_clear,
    input wire [2:0] channel_compare_mode,
    input wire [7:0] count_low_byte,
    input wire [7:0] count_high_byte,
    input wire       overflow_flag,
    input wire [2:0] channel_event_flag,
    input wire [2:0] channel_pin_oe_n
);
default clocking @(posedge clk);
endclocking
default disable iff (!resetn);
////////////////////////////////////////////////////////////////
sequence s_fast;
    timer_control_reg_mode == 2'h1 && prescale_divide_sel == 2'h0
        && timer_tick_speed_sel == 3'h0 && !count_low_write;
endsequence
sequence s_idle;
    timer_control_reg_mode == 2'h0 [*5];
endsequence
a_free_step: assert property (s_fast ##1 s_fast |=> count_low_byte == $past(count_low_byte) + 8'h01)
    else $error("count did not step");
a_write_clears: assert property (count_low_write |-> ##2 count_low_byte == 8'h00)
    else $error("write did not clear count");
a_stop_holds: assert property (timer_control_reg_mode == 2'h0 && !count_low_write |-> ##2 $stable(count_low_byte))
    else $error("stopped count moved");
a_high_holds: assert property (!count_low_read |=> $stable(count_high_byte))
    else $error("high byte changed without read");
a_flag_sticky: assert property (overflow_flag && !overflow_flag_clear |=> overflow_flag)
    else $error("flag dropped");
a_flag_clear: assert property (overflow_flag_clear && timer_control_reg_mode == 2'h0 |=> !overflow_flag)
    else $error("flag not cleared");
a_flag_run: assert property ($rose(overflow_flag) |-> $past(timer_control_reg_mode) != 2'h0)
    else $error("flag set while stopped");
a_event_idle: assert property (s_idle |-> channel_event_flag == 3'h0)
    else $error("event while stopped");
a_pin_dir: assert property ($stable(channel_compare_mode) |-> channel_pin_oe_n == ~channel_compare_mode)
    else $error("pin direction wrong");
endmodule
////////////////////////////////////////////////////////////////
bind tsbc_timer tsbc_checker i_tsbc_checker (.clk(clk), .resetn(resetn),
    .timer_tick_speed_sel(timer_tick_speed_sel), .timer_control_reg_mode(timer_control_reg_mode),
    .prescale_divide_sel(prescale_divide_sel), .count_low_read(count_low_read),
    .count_low_write(count_low_write), .overflow_flag_clear(overflow_flag_clear),
    .channel_compare_mode(channel_compare_mode), .count_low_byte(count_low_byte),
    .count_high_byte(count_high_byte), .overflow_flag(overflow_flag),
    .channel_event_flag(channel_event_flag), .channel_pin_oe_n(channel_pin_oe_n));

/* File: verif/tsbc_pins.sv */
// Model of the three channel pins outside the device
`timescale 1ns/10ps
module tsbc_pins
(
    input  wire       clk,
    input  wire [2:0] pin_out,
    input  wire [2:0] pin_oe_n,
    input  wire [2:0] flip_req,
    output wire [2:0] pin_in
);
reg [2:0] ext_q = 3'h0;
always @(posedge clk)
begin
    ext_q <= ext_q ^ flip_req;
end
assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_q);
endmodule

/* File: verif/tsbc_timer_bench.sv */
// Self-checking bench of the timer counter core
`timescale 1ns/10ps
`include "tsbc_defines.vh"
module tsbc_timer_bench;
typedef struct packed {logic [2:0] sel; logic [15:0] want;} tsbc_note_t;
reg clk = 1'b0;
reg resetn = 1'b0;
reg [2:0] spd = 3'h0;
reg [1:0] mode = 2'h0;
reg [1:0] div = 2'h0;
reg rd = 1'b0;
reg wr = 1'b0;
reg ovf_clr = 1'b0;
reg dsm_en = 1'b0;
reg [15:0] dsm_in = 16'h0000;
reg [15:0] cmp0 = 16'h0000;
reg [15:0] cmp1 = 16'h0000;
reg [2:0] cmode = 3'h0;
reg [5:0] cap_sel = 6'h00;
reg [8:0] act = 9'h000;
reg [2:0] radio_sel = 3'h0;
reg radio = 1'b0;
reg [2:0] flip = 3'h0;
reg [15:0] ev_cnt = 16'h0000;
wire [2:0] pin_in, pout, oe_n, evt;
wire [7:0] lo, hi;
wire ovf, dsm_out;
wire [47:0] cap;
wire [15:0] obs [0:6];
string nm [0:6] = '{"low", "high", "flag", "pins", "capture", "modulator", "events"};
tsbc_note_t notes [$];
tsbc_note_t cur;
event look;
int error_cnt = 0;
int n_checks = 0;
int k;
assign obs[0] = {8'h00, lo};
assign obs[1] = {8'h00, hi};
assign obs[2] = {15'h0000, ovf};
assign obs[3] = {12'h000, oe_n, pout[1]};
assign obs[4] = cap[15:0];
assign obs[5] = {15'h0000, dsm_out};
assign obs[6] = ev_cnt;
////////////////////////////////////////////////////////////////
tsbc_timer i_tsbc_timer (.clk(clk), .resetn(resetn), .timer_tick_speed_sel(spd), .timer_control_reg_mode(mode),
    .prescale_divide_sel(div), .delta_sigma_output_mode(dsm_en), .delta_sigma_input(dsm_in),
    .count_low_read(rd), .count_low_write(wr), .overflow_flag_clear(ovf_clr), .channel0_compare_value(cmp0),
    .channel1_compare_value(cmp1), .channel2_compare_value(16'h0000), .channel_compare_mode(cmode),
    .channel_capture_edge_sel(cap_sel), .channel_compare_action_sel(act), .channel_radio_capture_sel(radio_sel),
    .radio_event(radio), .channel_pin_in(pin_in), .count_low_byte(lo), .count_high_byte(hi),
    .overflow_flag(ovf), .channel_event_flag(evt), .channel_capture_value(cap), .channel_pin_out(pout),
    .channel_pin_oe_n(oe_n), .delta_sigma_out_q(dsm_out));
tsbc_pins i_tsbc_pins (.clk(clk), .pin_out(pout), .pin_oe_n(oe_n), .flip_req(flip), .pin_in(pin_in));
////////////////////////////////////////////////////////////////
initial
begin
    forever #4 clk = ~clk;
end
task step(input int n);
    repeat (n) @(posedge clk);
    #1;
endtask
task close_out;
    if (error_cnt == 0 && n_checks > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask
task check(input int sel, input [15:0] seen, input [15:0] want);
    n_checks++;
    if (seen !== want)
    begin
        error_cnt++;
        $display("unexpected %s: expected %h seen %h", nm[sel], want, seen);
    end
endtask
task note(input int sel, input [15:0] want);
    notes.push_back({sel[2:0], want});
    -> look;
endtask
task run(input [1:0] m, input [1:0] d, input [2:0] s, input int n);
    spd = s;
    div = d;
    mode = m;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
    step(n * ((d == 2'h0) ? 1 : (2 << (2 * d))) << s);
    mode = 2'h0;
endtask
task resume(input [1:0] m, input int n);
    mode = m;
    step(n);
    mode = 2'h0;
endtask
task peek(input [15:0] want);
    step(2 + $urandom_range(0, 9));
    note(0, {8'h00, want[7:0]});
    rd = 1'b1;
    step(1);
    rd = 1'b0;
    note(1, {8'h00, want[15:8]});
endtask
task clr_flag;
    ovf_clr = 1'b1;
    step(1);
    ovf_clr = 1'b0;
endtask
task cap_round(input [1:0] e, input r);
    cap_sel = {4'h0, e};
    radio_sel = {2'h0, r};
    k = $urandom_range(1, 9);
    step(1);
    spd = 3'h0;
    div = `TSBC_DIV_128;
    mode = `TSBC_MODE_FREE;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
    step(k * 128 + 19);
    repeat (2)
    begin
        if (r) radio = ~radio;
        else flip = 3'h1;
        step(1);
        flip = 3'h0;
        step(127);
    end
    mode = 2'h0;
endtask
////////////////////////////////////////////////////////////////
always @(look)
begin
    while (notes.size() > 0)
    begin
        cur = notes.pop_front();
        check(cur.sel, obs[cur.sel], cur.want);
    end
end
always @(posedge clk)
begin
    if (evt[1])
        ev_cnt <= ev_cnt + 16'h0001;
end
initial
begin
    #720000;
    error_cnt++;
    close_out();
end
initial
begin
    k = $urandom(32'h8562);
    dsm_en = $urandom_range(0, 1);
    dsm_in = $urandom;
    step(16);
    resetn = 1'b1;
    for (int i = 0; i < 4; i++) note(i, (i == 3) ? 16'h000E : 16'h0000);
    for (int d = 0; d < 4; d++)
    begin
        k = $urandom_range(2, 5);
        run(`TSBC_MODE_FREE, d[1:0], 3'($urandom_range(0, 2)), k);
        peek(k[15:0]);
    end
    k = $urandom_range(300, 900);
    run(`TSBC_MODE_FREE, `TSBC_DIV_1, 3'h0, k);
    peek(k[15:0]);
    wr = 1'b1;
    step(1);
    wr = 1'b0;
    peek(16'h0000);
    run(`TSBC_MODE_FREE, `TSBC_DIV_1, 3'h0, 65535);
    peek(16'hFFFF);
    note(2, 16'h0001);
    clr_flag();
    resume(`TSBC_MODE_FREE, 1);
    peek(16'h0000);
    note(2, 16'h0000);
    cmp0 = $urandom_range(5, 40);
    run(`TSBC_MODE_MODULO, `TSBC_DIV_1, 3'h0, cmp0);
    peek(cmp0);
    note(2, 16'h0001);
    clr_flag();
    resume(`TSBC_MODE_MODULO, 1);
    peek(16'h0000);
    run(`TSBC_MODE_UPDOWN, `TSBC_DIV_1, 3'h0, cmp0 + 2);
    peek(cmp0 - 16'h0002);
    note(2, 16'h0000);
    resume(`TSBC_MODE_UPDOWN, cmp0 - 2);
    note(2, 16'h0001);
    step(1);
    resume(`TSBC_MODE_UPDOWN, 1);
    peek(16'h0001);
    cmode = 3'h2;
    cmp1 = 16'h000A;
    for (int a = 0; a < 3; a++)
    begin
        act = {3'h0, a[2:0], 3'h0};
        run(`TSBC_MODE_FREE, `TSBC_DIV_1, 3'h0, 20);
        step(3);
        note(3, {12'h000, 3'h5, a != 1});
    end
    note(6, 16'h0003);
    cmode = 3'h0;
    for (int e = 0; e < 4; e++)
    begin
        cap_round(e[1:0], 1'b0);
        note(4, (e == 0) ? 16'h0000 : (e == 1) ? k[15:0] : k[15:0] + 16'h0001);
    end
    cap_round(2'h3, 1'b1);
    note(4, k[15:0]);
    dsm_en = 1'b0;
    step(1);
    note(5, 16'h0000);
    dsm_en = 1'b1;
    dsm_in = 16'hFFFF;
    run(`TSBC_MODE_FREE, `TSBC_DIV_1, 3'h0, 6);
    note(5, 16'h0001);
    step(2);
    close_out();
end
endmodule
